// file: inc/emd_regs.svh
`ifndef EMD_REGS_SVH
`define EMD_REGS_SVH
`define EMD_PAGE_SELECT_ADDR   8'haa
`define EMD_CONFIG_ADDR        8'hb2
`define EMD_PAGE_RESET         8'h00
`define EMD_CONFIG_RESET       5'h03
`define EMD_CONFIG_USED_MASK   8'h1f
`define EMD_MUX_BIT            4
`define EMD_MODE_HI            3
`define EMD_MODE_LO            2
`define EMD_ALE_HI             1
`define EMD_ALE_LO             0
`define EMD_ONCHIP_LIMIT       16'h1000
`define EMD_ONCHIP_MASK        16'h0fff
`define EMD_FIXED_CYCLES       4
`define EMD_STROBE_CYCLES      1
`endif

// file: inc/emd_pkg.sv
package emd_pkg;
    typedef enum logic [1:0] {
        EMD_MODE_ONCHIP,
        EMD_MODE_SPLIT_NOBANK,
        EMD_MODE_SPLIT_BANK,
        EMD_MODE_OFFCHIP
    } emd_mode_t;

    // CPU side external-move request
    typedef struct packed {
        logic        start;
        logic        wide;
        logic        write;
        logic [15:0] dptr;
        logic [7:0]  low_addr;
        logic [7:0]  wdata;
    } emd_req_t;

    // Pin drive for ports 1..4: value and enable per pin
    typedef struct packed {
        logic [7:0] p1_out;
        logic [7:0] p1_oe;
        logic [7:0] p2_out;
        logic [7:0] p2_oe;
        logic [7:0] p3_out;
        logic [7:0] p3_oe;
        logic [7:0] p4_out;
        logic [7:0] p4_oe;
    } emd_pins_t;
endpackage

// file: verilog/emd_ext_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "emd_regs.svh"

module emd_ext_mem (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // Special function register port
    input  wire logic             sfr_wr,
    input  wire logic [7:0]       sfr_addr,
    input  wire logic [7:0]       sfr_wdata,
    output logic      [7:0]       sfr_rdata,
    // External-move request from the core
    input  wire emd_pkg::emd_req_t req,
    input  wire logic [7:0]       timing_cycles,
    output logic                  onchip_sel,
    output logic      [11:0]      onchip_addr,
    output logic                  busy,
    output logic                  done,
    output logic      [7:0]       rdata,
    // Port pins
    input  wire logic [7:0]       p3_in,
    input  wire logic [7:0]       p4_in,
    output emd_pkg::emd_pins_t    pins
);
    import emd_pkg::*;

    typedef enum {
        ST_IDLE,
        ST_ALE_HI,
        ST_ALE_LO,
        ST_WAIT,
        ST_STROBE,
        ST_TAIL
    } emd_state_t;

    logic [7:0]  page_reg, page_next;
    logic [4:0]  cfg_reg, cfg_next;
    logic [7:0]  sfr_rdata_reg, sfr_rdata_next;
    emd_state_t  state_reg, state_next;
    logic [7:0]  cnt_reg, cnt_next;
    logic [15:0] addr_reg, addr_next;
    logic        drive_hi_reg, drive_hi_next;
    logic        write_reg, write_next;
    logic        mux_reg, mux_next;
    logic [7:0]  wdata_reg, wdata_next;
    logic        onchip_reg, onchip_next;
    logic [11:0] onaddr_reg, onaddr_next;
    logic        done_reg, done_next;
    logic [7:0]  rdata_reg, rdata_next;
    emd_pins_t   pins_reg, pins_next;
    logic [7:0]  p3_meta, p3_sync, p4_meta, p4_sync;

    emd_mode_t   mode;
    logic        mux_mode;
    logic [7:0]  ale_cycles;
    logic [15:0] eff_addr;
    logic        go_off;

    assign mode       = emd_mode_t'(cfg_reg[`EMD_MODE_HI:`EMD_MODE_LO]);
    assign mux_mode   = ~cfg_reg[`EMD_MUX_BIT];
    assign ale_cycles = {6'h00, cfg_reg[`EMD_ALE_HI:`EMD_ALE_LO]} + 8'h01;
    // Effective address: pointer or page:low byte
    assign eff_addr   = req.wide ? req.dptr : {page_reg, req.low_addr};

    // Off-chip decision per mode; boundary value itself counts as off-chip
    always_comb begin
        case (mode)
            EMD_MODE_ONCHIP:  go_off = 1'b0;
            EMD_MODE_OFFCHIP: go_off = 1'b1;
            default:          go_off = eff_addr >= `EMD_ONCHIP_LIMIT;
        endcase
    end

    // Register file
    always_comb begin
        page_next = page_reg;
        cfg_next  = cfg_reg;
        if (sfr_wr && sfr_addr == `EMD_PAGE_SELECT_ADDR) begin
            page_next = sfr_wdata;
        end
        if (sfr_wr && sfr_addr == `EMD_CONFIG_ADDR) begin
            cfg_next = sfr_wdata[4:0];
        end
        case (sfr_addr)
            `EMD_PAGE_SELECT_ADDR: sfr_rdata_next = page_reg;
            `EMD_CONFIG_ADDR:      sfr_rdata_next = {3'b000, cfg_reg};
            default:               sfr_rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            page_reg      <= `EMD_PAGE_RESET;
            cfg_reg       <= `EMD_CONFIG_RESET;
            sfr_rdata_reg <= 8'h00;
        end else begin
            page_reg      <= page_next;
            cfg_reg       <= cfg_next;
            sfr_rdata_reg <= sfr_rdata_next;
        end
    end

    // Data inputs cross from the pins
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            p3_meta <= 8'h00;
            p3_sync <= 8'h00;
            p4_meta <= 8'h00;
            p4_sync <= 8'h00;
        end else begin
            p3_meta <= p3_in;
            p3_sync <= p3_meta;
            p4_meta <= p4_in;
            p4_sync <= p4_meta;
        end
    end

    // Access sequencer and pin drive
    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        addr_next     = addr_reg;
        drive_hi_next = drive_hi_reg;
        write_next    = write_reg;
        mux_next      = mux_reg;
        wdata_next    = wdata_reg;
        onchip_next   = 1'b0;
        onaddr_next   = onaddr_reg;
        done_next     = 1'b0;
        rdata_next    = rdata_reg;
        pins_next     = '0;
        case (state_reg)
            ST_IDLE: begin
                if (req.start && !go_off) begin
                    onchip_next = 1'b1;
                    // Upper bits dropped so addresses wrap on the on-chip size
                    onaddr_next = eff_addr[11:0];
                    done_next   = 1'b1;
                end else if (req.start) begin
                    addr_next     = eff_addr;
                    // Bank modes drive the page; 8-bit no-bank and off-only leave latches
                    drive_hi_next = req.wide || mode == EMD_MODE_SPLIT_BANK;
                    write_next    = req.write;
                    wdata_next    = req.wdata;
                    mux_next      = mux_mode;
                    cnt_next      = mux_mode ? ale_cycles : timing_cycles;
                    state_next    = mux_mode ? ST_ALE_HI : ST_WAIT;
                end
            end
            ST_ALE_HI: begin
                pins_next.p1_out[5] = 1'b1;
                pins_next.p1_oe[5]  = 1'b1;
                pins_next.p3_out    = addr_reg[7:0];
                pins_next.p3_oe     = 8'hff;
                cnt_next            = cnt_reg - 8'h01;
                if (cnt_reg == 8'h01) begin
                    cnt_next   = ale_cycles;
                    state_next = ST_ALE_LO;
                end
            end
            ST_ALE_LO: begin
                cnt_next = cnt_reg - 8'h01;
                if (cnt_reg == 8'h01) begin
                    cnt_next   = timing_cycles;
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // Programmable setup time, then the strobe
                cnt_next = cnt_reg - 8'h01;
                if (cnt_reg <= 8'h01) begin
                    cnt_next   = 8'(`EMD_STROBE_CYCLES);
                    state_next = ST_STROBE;
                end
            end
            ST_STROBE: begin
                cnt_next   = 8'(`EMD_FIXED_CYCLES - 1);
                state_next = ST_TAIL;
            end
            ST_TAIL: begin
                // Fixed overhead cycles close the access
                cnt_next = cnt_reg - 8'h01;
                // Pin data needs two edges through the synchroniser
                if (cnt_reg == 8'(`EMD_FIXED_CYCLES - 2)) begin
                    rdata_next = mux_reg ? p3_sync : p4_sync;
                end
                if (cnt_reg == 8'h01) begin
                    done_next  = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        if (state_next != ST_IDLE && !(state_reg == ST_IDLE && state_next == ST_IDLE)
            && !(state_reg == ST_TAIL && done_next)) begin
            pins_next.p1_out[7:6] = 2'b11;
            pins_next.p1_oe[7:6]  = 2'b11;
            if (state_next == ST_STROBE) begin
                pins_next.p1_out[7:6] = write_next ? 2'b01 : 2'b10;
            end
            if (mux_next) begin
                pins_next.p1_oe[5]  = 1'b1;
                pins_next.p1_out[5] = state_next == ST_ALE_HI;
                pins_next.p3_out    = state_next == ST_ALE_HI ? addr_next[7:0] : wdata_next;
                pins_next.p3_oe     = (state_next == ST_ALE_HI || write_next) ? 8'hff : 8'h00;
            end else begin
                pins_next.p3_out = addr_next[7:0];
                pins_next.p3_oe  = 8'hff;
                pins_next.p4_out = wdata_next;
                pins_next.p4_oe  = write_next ? 8'hff : 8'h00;
            end
            pins_next.p2_out = addr_next[15:8];
            pins_next.p2_oe  = drive_hi_next ? 8'hff : 8'h00;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg    <= ST_IDLE;
            cnt_reg      <= 8'h00;
            addr_reg     <= 16'h0000;
            drive_hi_reg <= 1'b0;
            write_reg    <= 1'b0;
            mux_reg      <= 1'b0;
            wdata_reg    <= 8'h00;
            onchip_reg   <= 1'b0;
            onaddr_reg   <= 12'h000;
            done_reg     <= 1'b0;
            rdata_reg    <= 8'h00;
            pins_reg     <= '0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            addr_reg     <= addr_next;
            drive_hi_reg <= drive_hi_next;
            write_reg    <= write_next;
            mux_reg      <= mux_next;
            wdata_reg    <= wdata_next;
            onchip_reg   <= onchip_next;
            onaddr_reg   <= onaddr_next;
            done_reg     <= done_next;
            rdata_reg    <= rdata_next;
            pins_reg     <= pins_next;
        end
    end

    logic busy_reg;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= state_next != ST_IDLE;
        end
    end

    assign sfr_rdata   = sfr_rdata_reg;
    assign onchip_sel  = onchip_reg;
    assign onchip_addr = onaddr_reg;
    assign busy        = busy_reg;
    assign done        = done_reg;
    assign rdata       = rdata_reg;
    assign pins        = pins_reg;

    cfg_unused_a: assert property (@(posedge clock) disable iff (!rst_n)
        sfr_addr == `EMD_CONFIG_ADDR |=> sfr_rdata[7:5] == 3'b000)
        else $error("config high bits not zero");
    mode00_onchip_a: assert property (@(posedge clock) disable iff (!rst_n)
        req.start && state_reg == ST_IDLE && mode == EMD_MODE_ONCHIP |=> onchip_sel)
        else $error("mode 00 access went off-chip");
    mode11_off_a: assert property (@(posedge clock) disable iff (!rst_n)
        req.start && state_reg == ST_IDLE && mode == EMD_MODE_OFFCHIP |=> !onchip_sel && busy)
        else $error("mode 11 access stayed on-chip");
    boundary_off_a: assert property (@(posedge clock) disable iff (!rst_n)
        req.start && state_reg == ST_IDLE && mode != EMD_MODE_ONCHIP
        && eff_addr >= `EMD_ONCHIP_LIMIT |=> busy)
        else $error("boundary address not off-chip");
    ale_width_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(pins.p1_out[5]) && cfg_reg[1:0] == 2'b01 |-> pins.p1_out[5] [*2] ##1 !pins.p1_out[5])
        else $error("strobe high width wrong");
    nomux_noale_a: assert property (@(posedge clock) disable iff (!rst_n)
        !mux_reg |-> !pins.p1_oe[5])
        else $error("strobe driven when not multiplexed");
    idle_release_a: assert property (@(posedge clock) disable iff (!rst_n)
        !busy |-> pins == '0)
        else $error("pins held outside access");
    nobank_hi_a: assert property (@(posedge clock) disable iff (!rst_n)
        req.start && state_reg == ST_IDLE && !req.wide && mode == EMD_MODE_SPLIT_NOBANK
        |=> pins.p2_oe == 8'h00)
        else $error("upper address driven in no-bank mode");
    page_addr_a: assert property (@(posedge clock) disable iff (!rst_n)
        req.start && state_reg == ST_IDLE && !req.wide && mode == EMD_MODE_SPLIT_BANK
        && page_reg >= 8'h10 |=> pins.p2_out == $past(page_reg))
        else $error("upper address not page");
endmodule
`default_nettype wire

// file: sim/emd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module emd_mem_model (
    // Board strapping and port latches
    input  wire logic               clock,
    input  wire logic               nonmux,
    input  wire logic [7:0]         park_hi,
    // Pins
    input  wire emd_pkg::emd_pins_t pins,
    output logic      [7:0]         p3_in,
    output logic      [7:0]         p4_in
);
    import emd_pkg::*;
    logic [7:0]  mem [65536];
    logic [7:0]  lat_lo = 8'h00;
    logic [7:0]  last = 8'h00;
    logic [15:0] addr;
    logic [7:0]  rd;
    logic        rd_on;
    // Unwritten locations hold a pattern made from their address
    initial begin
        for (int a = 0; a < 65536; a++) mem[a] = 8'(a) ^ 8'(a >> 8) ^ 8'h3c;
    end
    // External latch follows the shared pins while strobe is high
    always @(posedge clock)
        if (pins.p1_oe[5] && pins.p1_out[5]) lat_lo <= pins.p3_out;
    // Undriven upper pins show the parked latch value
    assign addr = {pins.p2_oe[0] ? pins.p2_out : park_hi, nonmux ? pins.p3_out : lat_lo};
    assign rd_on = pins.p1_oe[6] && !pins.p1_out[6];
    assign rd = mem[addr];
    always @(posedge clock) begin
        if (rd_on) last <= rd;
        if (pins.p1_oe[7] && !pins.p1_out[7]) mem[addr] <= nonmux ? pins.p4_out : pins.p3_out;
    end
    // Released bus is not held: it shows the inverse of the last byte
    always @* begin
        p3_in = ~last;
        p4_in = ~last;
        if (rd_on && nonmux) p4_in = rd;
        else if (rd_on) p3_in = rd;
    end
endmodule
`default_nettype wire

// file: sim/test_ext_mem_mode_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "emd_regs.svh"
module test_ext_mem_mode_decode;
    import emd_pkg::*;
    typedef struct packed {
        logic [1:0]  mode;
        logic        wide;
        logic [15:0] addr;
        logic        off;
        logic [15:0] eff;
    } emd_row_t;
    localparam logic [7:0] PARK = 8'h9e;
    logic       clock = 1'b0;
    logic       rst_n = 1'b0;
    logic       sfr_wr = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] tim = 8'h01;
    logic       nonmux = 1'b0;
    emd_req_t   req = '0;
    emd_pins_t  pins;
    logic [7:0] sfr_rdata, rdata, p3_in, p4_in, got, rd_seen;
    logic       onchip_sel, busy, done, drv_seen, p2_seen, sel_seen, busy_seen;
    logic [11:0] onchip_addr, addr_seen;
    int         miscompares = 0;
    int         checks_done = 0;
    int         cyc, ale_n;
    emd_row_t   rows [9] = '{
        '{2'b00, 1'b0, 16'h1234, 1'b0, 16'h0234},
        '{2'b00, 1'b1, 16'hffff, 1'b0, 16'h0fff},
        '{2'b01, 1'b0, 16'h0fff, 1'b0, 16'h0fff},
        '{2'b01, 1'b0, 16'h1005, 1'b1, 16'h9e05},
        '{2'b10, 1'b0, 16'h1000, 1'b1, 16'h1000},
        '{2'b10, 1'b1, 16'h0fff, 1'b0, 16'h0fff},
        '{2'b10, 1'b1, 16'habcd, 1'b1, 16'habcd},
        '{2'b11, 1'b0, 16'h0007, 1'b1, 16'h9e07},
        '{2'b11, 1'b1, 16'h0010, 1'b1, 16'h0010}
    };
    always #12.5 clock = ~clock;
    emd_ext_mem dut_u (.clock(clock), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .req(req), .timing_cycles(tim),
        .onchip_sel(onchip_sel), .onchip_addr(onchip_addr), .busy(busy), .done(done),
        .rdata(rdata), .p3_in(p3_in), .p4_in(p4_in), .pins(pins));
    emd_mem_model mem_u (.clock(clock), .nonmux(nonmux), .park_hi(PARK), .pins(pins),
        .p3_in(p3_in), .p4_in(p4_in));
    function automatic logic [15:0] pat(input logic [15:0] a);
        return {8'h00, a[7:0] ^ a[15:8] ^ 8'h3c};
    endfunction
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge clock) #2;
        sfr_wr = 1'b0;
    endtask
    task automatic sfr_r(input logic [7:0] a);
        sfr_addr = a;
        @(posedge clock) #2;
        got = sfr_rdata;
    endtask
    // One access; counts edges from the start edge until done
    task automatic run(input logic w, input logic wr, input logic [15:0] a, input logic [7:0] d);
        req = '{1'b1, w, wr, a, a[7:0], d};
        ale_n = 0;
        drv_seen = 1'b0;
        p2_seen = 1'b0;
        @(posedge clock) #2;
        req.start = 1'b0;
        busy_seen = busy;
        // The cycle right after the start edge is the first one
        cyc = 1;
        while (done !== 1'b1 && cyc < 300) begin
            ale_n += int'(pins.p1_oe[5] && pins.p1_out[5]);
            drv_seen |= |{pins.p1_oe, pins.p2_oe, pins.p3_oe, pins.p4_oe};
            p2_seen |= |pins.p2_oe;
            @(posedge clock) #2;
            cyc++;
        end
        {sel_seen, addr_seen, rd_seen} = {onchip_sel, onchip_addr, rdata};
        chk("done", 16'h1, 16'(done));
        if (done !== 1'b1) report_and_stop();
        chk("busy at end", 16'h0, 16'(busy));
        @(posedge clock) #2;
        chk("done pulse", 16'h0, 16'(done));
        chk("select pulse", 16'h0, 16'(onchip_sel));
        chk("pins released", 16'h0, 16'(|{pins.p1_oe, pins.p2_oe, pins.p3_oe, pins.p4_oe}));
    endtask
    initial begin
        repeat (12) @(posedge clock);
        #2 rst_n = 1'b1;
        sfr_r(`EMD_PAGE_SELECT_ADDR);
        chk("page reset", 16'h00, 16'(got));
        sfr_r(`EMD_CONFIG_ADDR);
        chk("config reset", 16'h03, 16'(got));
        sfr_w(`EMD_CONFIG_ADDR, 8'hff);
        sfr_r(`EMD_CONFIG_ADDR);
        chk("config unused", 16'h1f, 16'(got));
        sfr_w(`EMD_PAGE_SELECT_ADDR, 8'ha5);
        sfr_r(`EMD_PAGE_SELECT_ADDR);
        chk("page rw", 16'ha5, 16'(got));
        sfr_r(8'h80);
        chk("unmapped", 16'h00, 16'(got));
        // Multiplexed, one setup cycle; one-cycle strobe, then strobes of one to four cycles
        foreach (rows[i]) begin
            sfr_w(`EMD_CONFIG_ADDR, {4'h0, rows[i].mode, 2'b00});
            sfr_w(`EMD_PAGE_SELECT_ADDR, rows[i].addr[15:8] ^ {8{rows[i].wide}});
            run(rows[i].wide, 1'b0, rows[i].addr, 8'h00);
            chk("on-chip select", 16'(!rows[i].off), 16'(sel_seen));
            if (!rows[i].off) chk("on-chip addr", rows[i].eff, 16'(addr_seen));
            else chk("read data", pat(rows[i].eff), 16'(rd_seen));
            chk("cycles", rows[i].off ? 16'd8 : 16'd1, 16'(cyc));
            chk("pins driven", 16'(rows[i].off), 16'(drv_seen));
            chk("busy", 16'(rows[i].off), 16'(busy_seen));
            chk("upper driven", 16'(rows[i].off && (rows[i].wide || rows[i].mode == 2'b10)),
                16'(p2_seen));
        end
        for (int w = 0; w < 4; w++) begin
            sfr_w(`EMD_CONFIG_ADDR, 8'h0c | 8'(w));
            run(1'b1, 1'b0, 16'h2000 + 16'(w), 8'h00);
            chk("strobe high", 16'(w + 1), 16'(ale_n));
            chk("mux cycles", 16'(2 * w + 8), 16'(cyc));
            chk("mux data", pat(16'h2000 + 16'(w)), 16'(rd_seen));
        end
        // Separate pins ignore the strobe field
        nonmux = 1'b1;
        tim = 8'h03;
        sfr_w(`EMD_CONFIG_ADDR, 8'h1f);
        run(1'b1, 1'b1, 16'h4321, 8'h6b);
        chk("separate cycles", 16'd8, 16'(cyc));
        chk("no strobe", 16'd0, 16'(ale_n));
        run(1'b1, 1'b0, 16'h4321, 8'h00);
        chk("read back", 16'h6b, 16'(rd_seen));
        sfr_w(`EMD_CONFIG_ADDR, 8'h1c);
        run(1'b0, 1'b0, 16'h0077, 8'h00);
        chk("parked page", pat({PARK, 8'h77}), 16'(rd_seen));
        chk("upper idle", 16'd0, 16'(p2_seen));
        // Reset in mid-access drops the pins and the registers
        sfr_w(`EMD_PAGE_SELECT_ADDR, 8'h5a);
        req = '{1'b1, 1'b1, 1'b0, 16'h8000, 8'h00, 8'h00};
        @(posedge clock) #2;
        req.start = 1'b0;
        chk("busy before reset", 16'h1, 16'(busy));
        rst_n = 1'b0;
        @(posedge clock) #2;
        rst_n = 1'b1;
        chk("reset busy", 16'h0, 16'(busy));
        chk("reset pins", 16'h0, 16'(|{pins.p1_oe, pins.p2_oe, pins.p3_oe, pins.p4_oe}));
        sfr_r(`EMD_CONFIG_ADDR);
        chk("config after reset", 16'h03, 16'(got));
        sfr_r(`EMD_PAGE_SELECT_ADDR);
        chk("page after reset", 16'h00, 16'(got));
        report_and_stop();
    end
endmodule
`default_nettype wire
